// [rtl/css_map.vh]
// register map, field positions and counts for the can status logic
`ifndef CSS_MAP_VH
`define CSS_MAP_VH

// register addresses
`define CSS_ADDR_W 8
`define CSS_ADDR_CONTROL 8'h00
`define CSS_ADDR_COMMAND 8'h01
`define CSS_ADDR_STATUS 8'h02
`define CSS_ADDR_TXBUF_LO 8'h0a
`define CSS_ADDR_TXBUF_HI 8'h13

// control register fields
`define CSS_CTL_RESET_REQ 0

// command register fields
`define CSS_CMD_SEND 0
`define CSS_CMD_CANCEL 1
`define CSS_CMD_RELEASE 2
`define CSS_CMD_CLR_OVR 3
`define CSS_CMD_READ_VAL 8'h0f

// status register fields
`define CSS_ST_BUS_OFF 7
`define CSS_ST_ERR_WARN 6
`define CSS_ST_TX_ACT 5
`define CSS_ST_RX_ACT 4
`define CSS_ST_TX_DONE 3
`define CSS_ST_TX_FREE 2
`define CSS_ST_OVERRUN 1
`define CSS_ST_RX_FULL 0

// reset values
`define CSS_RST_RESET_REQ 1'b1
`define CSS_RST_TX_DONE 1'b1
`define CSS_RST_TX_FREE 1'b1
`define CSS_RST_RDATA 8'h00

// counts
`define CSS_BUSFREE_RUN 11
`define CSS_BUSOFF_FREE_CNT 128
`define CSS_RX_BUFFERS 2

`endif

// [rtl/css_busfree.v]
// counter of consecutive recessive bits, pulses once per bus-free occurrence
`timescale 1ns/1ps
`include "css_map.vh"

module css_busfree #(
   parameter RUN_LEN = `CSS_BUSFREE_RUN,
   parameter CNT_W = 4
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire clear_i,
   input wire bit_tick_i,
   input wire bus_level_i,
   output reg free_pulse_o
);

   reg [CNT_W-1:0] run_q;
   reg [CNT_W-1:0] run_d;
   reg pulse_d;

   always @* begin
      run_d = run_q;
      pulse_d = 1'b0;
      if (clear_i) begin
         run_d = {CNT_W{1'b0}};
      end else if (bit_tick_i) begin
         if (!bus_level_i) begin
            run_d = {CNT_W{1'b0}};
         end else if (run_q == RUN_LEN[CNT_W-1:0] - 1'b1) begin
            run_d = {CNT_W{1'b0}};
            pulse_d = 1'b1;
         end else begin
            run_d = run_q + 1'b1;
         end
      end
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_q <= {CNT_W{1'b0}};
         free_pulse_o <= 1'b0;
      end else begin
         run_q <= run_d;
         free_pulse_o <= pulse_d;
      end
   end

endmodule

// [rtl/css_status.v]
// status register logic of the can controller with its register port
//
// Functional notes
// - status word at address 2 is read only; writes to it do nothing.
// - bit 7 reads 1 in bus-off, 0 while bus-on.
// - bit 6 reads 1 when an error counter reached warning limit.
// - bit 5 reads 1 while transmitting a message.
// - bit 4 reads 1 while receiving a message.
// - both activity bits low means the bus is idle.
// - bit 3 reads 1 when the last requested transmission succeeded.
// - a send request clears the transmission-complete bit.
// - bit 2 reads 1 when transmit buffer is free, 0 while locked.
// - writes to a locked transmit buffer are silently dropped.
// - cancel before transmission starts frees the buffer; an unsent message leaves complete bit low.
// - bit 1 set when both buffers full and another message arrives.
// - an overrun drops the message being received.
// - own accepted transmitted message is stored too; no room means overrun.
// - storing own message sets neither receive interrupt nor buffer-full bit.
// - an overrun never requests an overload frame.
// - bit 0 set when a new received message becomes available.
// - release clears bit 0 once no stored message remains; a further stored message sets it again.
// - entering bus-off sets reset-request until software clears it.
// - after that, 128 bus-free occurrences end bus-off and reset counters.
// - bus drivers float while in bus-off.
// - a bus-free occurrence is 11 consecutive recessive bits.
// - receive interrupt sets in the same cycle as buffer-full bit.
// - reset-request forces activity, complete, free, overrun and full bits.
`timescale 1ns/1ps
`include "css_map.vh"

module css_status #(
   parameter DATA_W = 8,
   parameter BUSOFF_FREE_CNT = `CSS_BUSOFF_FREE_CNT,
   parameter FREE_CNT_W = 8,
   parameter RX_BUFFERS = `CSS_RX_BUFFERS
) (
   input wire clk_i,
   input wire rst_n_i,
   // register port
   input wire [`CSS_ADDR_W-1:0] reg_addr_i,
   input wire [DATA_W-1:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [DATA_W-1:0] reg_rdata_o,
   // protocol core events
   input wire tx_active_i,
   input wire rx_active_i,
   input wire err_warn_i,
   input wire bus_off_entry_i,
   input wire tx_started_i,
   input wire tx_done_ok_i,
   input wire rx_first_byte_i,
   input wire rx_own_msg_i,
   input wire rx_msg_done_i,
   input wire bit_tick_i,
   input wire bus_level_i,
   input wire rx_int_en_i,
   input wire overrun_int_en_i,
   // controls toward the core and buffers
   output reg reset_request_o,
   output reg tx_request_o,
   output reg rx_drop_o,
   output reg rx_store_en_o,
   output reg rx_int_set_o,
   output reg overrun_int_set_o,
   output reg err_cnt_clear_o,
   output reg bus_drv_en_o,
   output reg bus_idle_o,
   output reg tbuf_we_o,
   output reg [`CSS_ADDR_W-1:0] tbuf_addr_o,
   output reg [DATA_W-1:0] tbuf_data_o
);

   localparam RXC_W = 2;
   localparam [RXC_W-1:0] RX_FULL_CNT = RX_BUFFERS[RXC_W-1:0];

   reg bus_off_q;
   reg bus_off_d;
   reg err_warn_q;
   reg err_warn_d;
   reg tx_act_q;
   reg rx_act_q;
   reg tx_done_q;
   reg tx_done_d;
   reg tx_free_q;
   reg tx_free_d;
   reg overrun_q;
   reg overrun_d;
   reg rx_full_q;
   reg rx_full_d;
   reg reset_req_q;
   reg reset_req_d;
   reg tx_pend_q;
   reg tx_pend_d;
   reg tx_busy_q;
   reg tx_busy_d;
   reg [RXC_W-1:0] rx_cnt_q;
   reg [RXC_W-1:0] rx_cnt_d;
   reg rx_drop_q;
   reg rx_drop_d;
   reg [FREE_CNT_W-1:0] free_cnt_q;
   reg [FREE_CNT_W-1:0] free_cnt_d;
   reg recover_d;
   reg [DATA_W-1:0] rdata_d;

   wire wr_ctl;
   wire wr_cmd;
   wire cmd_send;
   wire cmd_cancel;
   wire cmd_release;
   wire cmd_clr_ovr;
   wire wr_tbuf;
   wire free_pulse;
   wire [DATA_W-1:0] status_word;

   assign wr_ctl = reg_wr_i && (reg_addr_i == `CSS_ADDR_CONTROL);
   assign wr_cmd = reg_wr_i && (reg_addr_i == `CSS_ADDR_COMMAND);
   assign cmd_send = wr_cmd && reg_wdata_i[`CSS_CMD_SEND];
   assign cmd_cancel = wr_cmd && reg_wdata_i[`CSS_CMD_CANCEL];
   assign cmd_release = wr_cmd && reg_wdata_i[`CSS_CMD_RELEASE];
   assign cmd_clr_ovr = wr_cmd && reg_wdata_i[`CSS_CMD_CLR_OVR];
   assign wr_tbuf = reg_wr_i && (reg_addr_i >= `CSS_ADDR_TXBUF_LO) && (reg_addr_i <= `CSS_ADDR_TXBUF_HI);

   css_busfree #(
      .RUN_LEN(`CSS_BUSFREE_RUN),
      .CNT_W(4)
   ) u_busfree (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .clear_i(reset_req_q),
      .bit_tick_i(bit_tick_i),
      .bus_level_i(bus_level_i),
      .free_pulse_o(free_pulse)
   );

   assign status_word[`CSS_ST_BUS_OFF] = bus_off_q;
   assign status_word[`CSS_ST_ERR_WARN] = err_warn_q;
   assign status_word[`CSS_ST_TX_ACT] = tx_act_q;
   assign status_word[`CSS_ST_RX_ACT] = rx_act_q;
   assign status_word[`CSS_ST_TX_DONE] = tx_done_q;
   assign status_word[`CSS_ST_TX_FREE] = tx_free_q;
   assign status_word[`CSS_ST_OVERRUN] = overrun_q;
   assign status_word[`CSS_ST_RX_FULL] = rx_full_q;

   always @* begin
      bus_off_d = bus_off_q;
      reset_req_d = reset_req_q;
      free_cnt_d = free_cnt_q;
      recover_d = 1'b0;
      if (wr_ctl) begin
         reset_req_d = reg_wdata_i[`CSS_CTL_RESET_REQ];
      end
      if (bus_off_q && !reset_req_q) begin
         if (free_pulse) begin
            if (free_cnt_q == BUSOFF_FREE_CNT[FREE_CNT_W-1:0] - 1'b1) begin
               free_cnt_d = {FREE_CNT_W{1'b0}};
               bus_off_d = 1'b0;
               recover_d = 1'b1;
            end else begin
               free_cnt_d = free_cnt_q + 1'b1;
            end
         end
      end else begin
         free_cnt_d = {FREE_CNT_W{1'b0}};
      end
      if (bus_off_entry_i) begin
         bus_off_d = 1'b1;
         reset_req_d = 1'b1;
         free_cnt_d = {FREE_CNT_W{1'b0}};
         recover_d = 1'b0;
      end
   end

   always @* begin
      err_warn_d = err_warn_i;
      if (recover_d) begin
         err_warn_d = 1'b0;
      end
   end

   // transmit side
   always @* begin
      tx_done_d = tx_done_q;
      tx_free_d = tx_free_q;
      tx_pend_d = tx_pend_q;
      tx_busy_d = tx_busy_q;
      if (tx_started_i && tx_pend_q) begin
         tx_busy_d = 1'b1;
      end
      if (cmd_cancel && tx_pend_q && !tx_busy_q && !tx_started_i) begin
         tx_pend_d = 1'b0;
         tx_free_d = 1'b1;
      end
      if (tx_done_ok_i && tx_pend_q) begin
         tx_done_d = 1'b1;
         tx_free_d = 1'b1;
         tx_pend_d = 1'b0;
         tx_busy_d = 1'b0;
      end
      if (cmd_send && tx_free_q && !reset_req_q) begin
         tx_done_d = 1'b0;
         tx_free_d = 1'b0;
         tx_pend_d = 1'b1;
         tx_busy_d = 1'b0;
      end
      if (reset_req_d) begin
         tx_done_d = `CSS_RST_TX_DONE;
         tx_free_d = `CSS_RST_TX_FREE;
         tx_pend_d = 1'b0;
         tx_busy_d = 1'b0;
      end
   end

   // receive side
   always @* begin
      overrun_d = overrun_q;
      rx_full_d = rx_full_q;
      rx_cnt_d = rx_cnt_q;
      rx_drop_d = rx_drop_q;
      if (cmd_release && rx_cnt_q != {RXC_W{1'b0}}) begin
         rx_cnt_d = rx_cnt_q - 1'b1;
      end
      if (cmd_release) begin
         rx_full_d = (rx_cnt_d != {RXC_W{1'b0}});
      end
      if (cmd_clr_ovr) begin
         overrun_d = 1'b0;
      end
      if (rx_first_byte_i) begin
         rx_drop_d = 1'b0;
         if (rx_cnt_q == RX_FULL_CNT) begin
            overrun_d = 1'b1;
            rx_drop_d = 1'b1;
         end
      end
      // own message stored but not kept
      if (rx_msg_done_i && !rx_drop_q && !rx_own_msg_i && rx_cnt_d != RX_FULL_CNT) begin
         rx_cnt_d = rx_cnt_d + 1'b1;
         rx_full_d = 1'b1;
      end
      if (rx_msg_done_i) begin
         rx_drop_d = 1'b0;
      end
      if (reset_req_d) begin
         overrun_d = 1'b0;
         rx_full_d = 1'b0;
         rx_cnt_d = {RXC_W{1'b0}};
         rx_drop_d = 1'b0;
      end
   end

   always @* begin
      case (reg_addr_i)
         `CSS_ADDR_CONTROL: begin
            rdata_d = {{(DATA_W-1){1'b0}}, reset_req_q};
         end
         `CSS_ADDR_COMMAND: begin
            rdata_d = `CSS_CMD_READ_VAL;
         end
         `CSS_ADDR_STATUS: begin
            rdata_d = status_word;
         end
         default: begin
            rdata_d = `CSS_RST_RDATA;
         end
      endcase
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_off_q <= 1'b0;
         err_warn_q <= 1'b0;
         tx_act_q <= 1'b0;
         rx_act_q <= 1'b0;
         tx_done_q <= `CSS_RST_TX_DONE;
         tx_free_q <= `CSS_RST_TX_FREE;
         overrun_q <= 1'b0;
         rx_full_q <= 1'b0;
         reset_req_q <= `CSS_RST_RESET_REQ;
         tx_pend_q <= 1'b0;
         tx_busy_q <= 1'b0;
         rx_cnt_q <= {RXC_W{1'b0}};
         rx_drop_q <= 1'b0;
         free_cnt_q <= {FREE_CNT_W{1'b0}};
      end else begin
         bus_off_q <= bus_off_d;
         err_warn_q <= err_warn_d;
         tx_act_q <= tx_active_i && !reset_req_d;
         rx_act_q <= rx_active_i && !reset_req_d;
         tx_done_q <= tx_done_d;
         tx_free_q <= tx_free_d;
         overrun_q <= overrun_d;
         rx_full_q <= rx_full_d;
         reset_req_q <= reset_req_d;
         tx_pend_q <= tx_pend_d;
         tx_busy_q <= tx_busy_d;
         rx_cnt_q <= rx_cnt_d;
         rx_drop_q <= rx_drop_d;
         free_cnt_q <= free_cnt_d;
      end
   end

   // outputs toward core and cpu
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= `CSS_RST_RDATA;
         reset_request_o <= `CSS_RST_RESET_REQ;
         tx_request_o <= 1'b0;
         rx_drop_o <= 1'b0;
         rx_store_en_o <= 1'b0;
         rx_int_set_o <= 1'b0;
         overrun_int_set_o <= 1'b0;
         err_cnt_clear_o <= 1'b0;
         bus_drv_en_o <= 1'b0;
         bus_idle_o <= 1'b1;
         tbuf_we_o <= 1'b0;
         tbuf_addr_o <= {`CSS_ADDR_W{1'b0}};
         tbuf_data_o <= {DATA_W{1'b0}};
      end else begin
         if (reg_rd_i) begin
            reg_rdata_o <= rdata_d;
         end else begin
            reg_rdata_o <= `CSS_RST_RDATA;
         end
         reset_request_o <= reset_req_d;
         tx_request_o <= tx_pend_d;
         // overrun only drops, no frame request
         rx_drop_o <= rx_first_byte_i && (rx_cnt_q == RX_FULL_CNT) && !reset_req_d;
         // own message storage allowed when room
         rx_store_en_o <= rx_first_byte_i && (rx_cnt_q != RX_FULL_CNT) && !reset_req_d;
         // interrupt with full bit, not for own
         rx_int_set_o <= rx_int_en_i && rx_full_d && !rx_full_q;
         overrun_int_set_o <= overrun_int_en_i && overrun_d && !overrun_q;
         err_cnt_clear_o <= recover_d;
         bus_drv_en_o <= !bus_off_d;
         // idle when both activity bits low
         bus_idle_o <= !(tx_active_i && !reset_req_d) && !(rx_active_i && !reset_req_d);
         tbuf_we_o <= wr_tbuf && tx_free_q;
         tbuf_addr_o <= reg_addr_i;
         tbuf_data_o <= reg_wdata_i;
      end
   end

endmodule

// [test/css_status_props.sv]
// concurrent assertions on the css_status ports
`timescale 1ns/1ps
`include "css_map.vh"
module css_status_props (
   input wire clk_i,
   input wire rst_n_i,
   input wire [`CSS_ADDR_W-1:0] reg_addr_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_rdata_o,
   input wire tx_active_i,
   input wire rx_active_i,
   input wire bus_off_entry_i,
   input wire rx_first_byte_i,
   input wire rx_own_msg_i,
   input wire rx_msg_done_i,
   input wire rx_int_en_i,
   input wire reset_request_o,
   input wire tx_request_o,
   input wire rx_drop_o,
   input wire rx_store_en_o,
   input wire rx_int_set_o,
   input wire overrun_int_set_o,
   input wire bus_drv_en_o,
   input wire bus_idle_o,
   input wire tbuf_we_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_rdata_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
      else $error("read data not zero outside read cycle");
   a_busoff_float: assert property (bus_off_entry_i |=> reset_request_o && !bus_drv_en_o)
      else $error("bus-off entry did not float drivers");
   a_idle_busy: assert property ((tx_active_i && !reset_request_o) [*3] |-> !bus_idle_o)
      else $error("idle while transmitting");
   a_idle_quiet: assert property ((!tx_active_i && !rx_active_i) [*3] |-> bus_idle_o)
      else $error("not idle with no activity");
   a_store_or_drop: assert property (rx_first_byte_i |=> reset_request_o ? !(rx_store_en_o || rx_drop_o)
      : (rx_store_en_o ^ rx_drop_o))
      else $error("first byte neither stored nor dropped");
   a_overrun_drop: assert property (overrun_int_set_o |-> rx_drop_o && $past(rx_first_byte_i))
      else $error("overrun without drop of message");
   a_locked_write: assert property (tx_request_o && reg_wr_i |=> !tbuf_we_o)
      else $error("write accepted into locked buffer");
   a_tbuf_window: assert property (tbuf_we_o |-> $past(reg_wr_i)
      && $past(reg_addr_i) >= 8'h0a && $past(reg_addr_i) <= 8'h13)
      else $error("buffer write without matching bus write");
   a_rx_int_cause: assert property (rx_int_set_o |-> $past(rx_msg_done_i)
      && !$past(rx_own_msg_i) && $past(rx_int_en_i))
      else $error("receive interrupt without foreign message");
   c_drop: cover property (rx_drop_o);
   c_rx_int: cover property (rx_int_set_o);
   c_busoff: cover property (bus_off_entry_i ##1 !bus_drv_en_o);
endmodule
bind css_status css_status_props u_css_status_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .tx_active_i(tx_active_i), .rx_active_i(rx_active_i), .bus_off_entry_i(bus_off_entry_i),
   .rx_first_byte_i(rx_first_byte_i), .rx_own_msg_i(rx_own_msg_i), .rx_msg_done_i(rx_msg_done_i),
   .rx_int_en_i(rx_int_en_i), .reset_request_o(reset_request_o), .tx_request_o(tx_request_o),
   .rx_drop_o(rx_drop_o), .rx_store_en_o(rx_store_en_o), .rx_int_set_o(rx_int_set_o),
   .overrun_int_set_o(overrun_int_set_o), .bus_drv_en_o(bus_drv_en_o), .bus_idle_o(bus_idle_o),
   .tbuf_we_o(tbuf_we_o));

// [test/css_status_tb.sv]
// self-checking bench of the can status logic
`timescale 1ns/1ps
`include "css_map.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
   $display("Error %0t: got %h expected %h", $time, g, e); end end
module css_status_tb;
   localparam int FREES = 4;
   logic clk_i = 0;
   logic rst_n_i = 0;
   logic [7:0] addr = 0, wdata = 0, rdata, taddr, tdata;
   logic wr = 0, rd = 0, txa = 0, rxa = 0, ew = 0, own = 0, tick = 0, lvl = 0, rien = 0, oien = 0;
   logic [4:0] ev = 0;
   logic rreq, txreq, drop, store, rint, oint, eclr, drv, idle, twe;
   logic [31:0] seed = 32'hed1497fe;
   int n_errors = 0, checks = 0, cyc = 0, nclr = 0;
   css_status #(.BUSOFF_FREE_CNT(FREES)) u_css_status (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdata), .tx_active_i(txa), .rx_active_i(rxa), .err_warn_i(ew),
      .bus_off_entry_i(ev[0]), .tx_started_i(ev[1]), .tx_done_ok_i(ev[2]), .rx_first_byte_i(ev[3]),
      .rx_own_msg_i(own), .rx_msg_done_i(ev[4]), .bit_tick_i(tick), .bus_level_i(lvl),
      .rx_int_en_i(rien), .overrun_int_en_i(oien), .reset_request_o(rreq), .tx_request_o(txreq),
      .rx_drop_o(drop), .rx_store_en_o(store), .rx_int_set_o(rint), .overrun_int_set_o(oint),
      .err_cnt_clear_o(eclr), .bus_drv_en_o(drv), .bus_idle_o(idle), .tbuf_we_o(twe),
      .tbuf_addr_o(taddr), .tbuf_data_o(tdata));
   always #20 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc++;
      if (eclr === 1'b1)
         nclr++;
      if (cyc == 3000) begin
         n_errors++;
         summarize();
      end
   end
   task automatic summarize();
      if (n_errors == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [7:0] act_st(input logic t, input logic r, input logic e);
      return {1'b0, e, t, r, 4'hc};
   endfunction
   // one bus cycle, outputs settled on return
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      @(posedge clk_i);
      wr <= 0;
      rd <= 0;
      #1;
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
      acc(0, a, 8'h00);
      `CHK(rdata, e)
   endtask
   task automatic pulse(input logic [4:0] m);
      @(posedge clk_i);
      ev <= m;
      @(posedge clk_i);
      ev <= 0;
      #1;
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1;
      chk_rd(8'h02, 8'h0c);
      acc(1, 8'h00, 8'h00);
      acc(1, 8'h02, 8'hff);
      chk_rd(8'h02, 8'h0c);
      chk_rd(8'h02, 8'h0c);
      chk_rd(8'h30, 8'h00);
      for (int i = 0; i < 24; i++) begin
         seed = xs(seed);
         @(posedge clk_i);
         txa <= seed[0];
         rxa <= seed[1];
         ew <= seed[2];
         chk_rd(8'h02, act_st(seed[0], seed[1], seed[2]));
         `CHK(idle, !(seed[0] | seed[1]))
      end
      @(posedge clk_i);
      txa <= 0;
      rxa <= 0;
      ew <= 0;
      rien <= 1;
      oien <= 1;
      acc(1, 8'h01, 8'h01);
      `CHK(txreq, 1'b1)
      chk_rd(8'h02, 8'h00);
      acc(1, 8'h0a, seed[7:0]);
      `CHK(twe, 1'b0)
      pulse(5'h02);
      pulse(5'h04);
      chk_rd(8'h02, 8'h0c);
      acc(1, 8'h13, seed[15:8]);
      `CHK({twe, taddr, tdata}, {1'b1, 8'h13, seed[15:8]})
      acc(1, 8'h01, 8'h01);
      acc(1, 8'h01, 8'h02);
      chk_rd(8'h02, 8'h04);
      for (int i = 0; i < 2; i++) begin
         pulse(5'h08);
         `CHK({store, drop}, 2'b10)
         pulse(5'h10);
         `CHK(rint, i == 0)
      end
      chk_rd(8'h02, 8'h05);
      pulse(5'h08);
      `CHK({store, drop, oint}, 3'b011)
      chk_rd(8'h02, 8'h07);
      acc(1, 8'h01, 8'h04);
      repeat (2) @(posedge clk_i);
      acc(1, 8'h01, 8'h04);
      chk_rd(8'h02, 8'h06);
      acc(1, 8'h01, 8'h08);
      chk_rd(8'h02, 8'h04);
      @(posedge clk_i);
      own <= 1;
      pulse(5'h08);
      pulse(5'h10);
      `CHK(rint, 1'b0)
      chk_rd(8'h02, 8'h04);
      pulse(5'h01);
      `CHK({rreq, drv}, 2'b10)
      chk_rd(8'h02, 8'h8c);
      acc(1, 8'h00, 8'h00);
      `CHK(rreq, 1'b0)
      @(posedge clk_i);
      lvl <= 1;
      for (int i = 0; i < 11 * FREES; i++) begin
         @(posedge clk_i);
         tick <= 1;
         @(posedge clk_i);
         tick <= 0;
         if (i == 11 * FREES - 2)
            chk_rd(8'h02, 8'h8c);
      end
      repeat (3) @(posedge clk_i);
      chk_rd(8'h02, 8'h0c);
      `CHK(nclr == 1, 1'b1)
      `CHK(drv, 1'b1)
      summarize();
   end
endmodule
